/* File: rtl/rxb_rx_manager.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rxb_rx_manager import rxb_pkg::*; #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_q,
	// receive byte stream from the mac
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	input  wire logic [15:0] rx_match,
	output logic             rx_ready_q,
	// system memory master
	output logic             mem_req_q,
	output logic             mem_we_q,
	output logic      [31:0] mem_addr_q,
	output logic      [31:0] mem_wdata_q,
	output logic      [3:0]  mem_be_q,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata
);
	rxb_state_t          state_q;
	logic                rx_en_q;
	logic                stat_wen_q;
	logic [1:0]          cfg_off_q;
	logic [31:2]         qbase_q;
	logic [31:0]         desc_q;
	logic [31:2]         buf_q;
	logic                wrap_q;
	logic [6:0]          bptr_q;
	logic                first_q;
	logic                last_q;
	logic                full_q;
	logic [31:0]         wbuf_q;
	logic [3:0]          be_q;
	logic [ST_LEN_W-1:0] len_q;
	logic [15:0]         match_q;
	logic                res_err_q;
	logic                late_q;
	logic                res_pulse_q;
	logic                frame_pulse_q;
	logic [6:0]          wait_q;
	logic [31:0]         wmerge;
	logic [3:0]          be_n;
	logic [31:0]         next_desc;
	logic [31:0]         stat_word;
	logic                take;
	logic                wr_ctrl;
	logic                wr_qptr;
	logic [CNT_W-1:0]    cnt_val [NUM_CNT];
	logic [NUM_CNT-1:0]  cnt_inc;

	assign take    = rx_ready_q && rx_valid;
	assign wr_ctrl = reg_wr && (reg_addr == OFF_NET_CTRL);
	assign wr_qptr = reg_wr && (reg_addr == OFF_RX_QPTR);
	assign next_desc = wrap_q ? {qbase_q, 2'b00} : desc_q + DESC_BYTES;
	assign cnt_inc = {res_pulse_q, frame_pulse_q};

	always_comb begin
		wmerge = wbuf_q;
		wmerge[8*bptr_q[1:0] +: 8] = rx_data;
		be_n = be_q | (4'h1 << bptr_q[1:0]);
	end

	rxb_status_word u_status (
		.match_hi (match_q),
		.eof      (last_q),
		.sof      (first_q),
		.offset   (first_q ? cfg_off_q : 2'b00),
		.length   (len_q),
		.word     (stat_word)
	);

	// control and configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_en_q    <= 1'b0;
			stat_wen_q <= 1'b0;
			cfg_off_q  <= 2'b00;
			qbase_q    <= RST_ZERO[31:2];
		end else if (clk_en) begin
			if (wr_ctrl) begin
				rx_en_q    <= reg_wdata[NCR_RX_EN];
				stat_wen_q <= reg_wdata[NCR_STAT_WEN];
			end
			if (reg_wr && reg_addr == OFF_NET_CFG) begin
				cfg_off_q <= reg_wdata[CFG_OFF_LO +: 2];
			end
			if (wr_qptr) begin
				qbase_q <= reg_wdata[31:2];
			end
		end
	end

	// sticky status flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_err_q <= 1'b0;
			late_q    <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == OFF_RX_STAT) begin
				if (reg_wdata[RSR_RES_ERR]) begin
					res_err_q <= 1'b0;
				end
				if (reg_wdata[RSR_LATE]) begin
					late_q <= 1'b0;
				end
			end
			if (res_pulse_q) begin
				res_err_q <= 1'b1;
			end
			if (mem_req_q && !mem_ack && wait_q == 7'(GRANT_CYC)) begin
				late_q <= 1'b1;
			end
		end
	end

	// grant latency watch: the receive fifo overruns if the bus waits too long
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 7'h00;
		end else if (clk_en) begin
			if (!mem_req_q || mem_ack) begin
				wait_q <= 7'h00;
			end else if (wait_q != 7'h7f) begin
				wait_q <= wait_q + 7'h01;
			end
		end
	end

	// descriptor walk and buffer filling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q       <= S_IDLE;
			desc_q        <= RST_ZERO;
			buf_q         <= RST_ZERO[31:2];
			wrap_q        <= 1'b0;
			bptr_q        <= 7'h00;
			first_q       <= 1'b0;
			last_q        <= 1'b0;
			full_q        <= 1'b0;
			wbuf_q        <= RST_ZERO;
			be_q          <= 4'h0;
			len_q         <= '0;
			match_q       <= 16'h0000;
			rx_ready_q    <= 1'b0;
			mem_req_q     <= 1'b0;
			mem_we_q      <= 1'b0;
			mem_addr_q    <= RST_ZERO;
			mem_wdata_q   <= RST_ZERO;
			mem_be_q      <= 4'h0;
			res_pulse_q   <= 1'b0;
			frame_pulse_q <= 1'b0;
		end else if (clk_en) begin
			res_pulse_q   <= 1'b0;
			frame_pulse_q <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					if (wr_qptr) begin
						desc_q <= {reg_wdata[31:2], 2'b00};
					end else if (rx_en_q && rx_valid) begin
						first_q    <= 1'b1;
						last_q     <= 1'b0;
						len_q      <= '0;
						mem_req_q  <= 1'b1;
						mem_we_q   <= 1'b0;
						mem_addr_q <= desc_q;
						mem_be_q   <= 4'hf;
						state_q    <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (mem_ack) begin
						mem_req_q  <= 1'b0;
						rx_ready_q <= 1'b1;
						if (mem_rdata[D0_OWN]) begin
							res_pulse_q <= 1'b1;
							state_q     <= S_DROP;
						end else begin
							buf_q   <= mem_rdata[31:2];
							wrap_q  <= mem_rdata[D0_WRAP];
							bptr_q  <= first_q ? {5'h00, cfg_off_q} : 7'h00;
							be_q    <= 4'h0;
							full_q  <= 1'b0;
							state_q <= S_FILL;
						end
					end
				end
				S_FILL: begin
					if (take) begin
						rx_ready_q <= 1'b0;
						wbuf_q     <= wmerge;
						be_q       <= be_n;
						len_q      <= len_q + 1'b1;
						if (bptr_q[1:0] == 2'b11 || rx_last || bptr_q == 7'(BUF_BYTES - 1)) begin
							last_q      <= rx_last;
							full_q      <= (bptr_q == 7'(BUF_BYTES - 1));
							match_q     <= rx_match;
							mem_req_q   <= 1'b1;
							mem_we_q    <= 1'b1;
							mem_addr_q  <= {buf_q, 2'b00} + {25'h0, bptr_q[6:2], 2'b00};
							mem_wdata_q <= wmerge;
							mem_be_q    <= be_n;
							state_q     <= S_WRD;
						end else begin
							bptr_q <= bptr_q + 7'h01;
						end
					end else begin
						rx_ready_q <= 1'b1;
					end
				end
				S_WRD: begin
					if (mem_ack) begin
						bptr_q <= bptr_q + 7'h01;
						be_q   <= 4'h0;
						wbuf_q <= RST_ZERO;
						if (last_q || full_q) begin
							mem_addr_q  <= desc_q + DESC_STAT_OFF;
							mem_wdata_q <= stat_word;
							mem_be_q    <= 4'hf;
							state_q     <= S_STAT;
						end else begin
							mem_req_q  <= 1'b0;
							rx_ready_q <= 1'b1;
							state_q    <= S_FILL;
						end
					end
				end
				S_STAT: begin
					if (mem_ack) begin
						// ownership goes last so software never sees a stale status
						mem_addr_q  <= desc_q;
						mem_wdata_q <= {buf_q, wrap_q, 1'b1};
						state_q     <= S_OWN;
					end
				end
				S_OWN: begin
					if (mem_ack) begin
						desc_q  <= next_desc;
						first_q <= 1'b0;
						if (last_q) begin
							mem_req_q     <= 1'b0;
							frame_pulse_q <= 1'b1;
							state_q       <= S_IDLE;
						end else begin
							mem_we_q   <= 1'b0;
							mem_addr_q <= next_desc;
							state_q    <= S_FETCH;
						end
					end
				end
				S_DROP: begin
					// same one-byte-per-two-cycles pace as filling, bytes are discarded
					rx_ready_q <= !take;
					if (take && rx_last) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
			rxb_stat_ctr #(
				.WIDTH (CNT_W)
			) u_cnt (
				.clk      (clk),
				.rst_n    (rst_n),
				.clk_en   (clk_en),
				.inc      (cnt_inc[gi]),
				.count_en (rx_en_q),
				.rd       (reg_rd && reg_addr == OFF_CNT_BASE + 8'(4 * gi)),
				.wr       (reg_wr && reg_addr == OFF_CNT_BASE + 8'(4 * gi)),
				.wr_en    (stat_wen_q),
				.wdata    (reg_wdata[CNT_W-1:0]),
				.value    (cnt_val[gi])
			);
		end
	endgenerate

	// read data stands in the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= RST_ZERO;
		end else if (clk_en) begin
			reg_rdata_q <= RST_ZERO;
			if (reg_rd) begin
				unique case (reg_addr)
					OFF_NET_CTRL: begin
						reg_rdata_q[NCR_RX_EN]    <= rx_en_q;
						reg_rdata_q[NCR_STAT_WEN] <= stat_wen_q;
					end
					OFF_NET_CFG:   reg_rdata_q[CFG_OFF_LO +: 2] <= cfg_off_q;
					OFF_RX_QPTR:   reg_rdata_q <= desc_q;
					OFF_RX_STAT: begin
						reg_rdata_q[0]           <= !state_q[0];
						reg_rdata_q[RSR_RES_ERR] <= res_err_q;
						reg_rdata_q[RSR_LATE]    <= late_q;
					end
					OFF_CNT_FRAME: reg_rdata_q[CNT_W-1:0] <= cnt_val[0];
					OFF_CNT_RES:   reg_rdata_q[CNT_W-1:0] <= cnt_val[1];
					default:       reg_rdata_q <= RST_ZERO;
				endcase
			end
		end
	end
endmodule : rxb_rx_manager

/* File: common/rxb_pkg.sv */
package rxb_pkg;
	// register map, byte addresses on the plain register port
	localparam logic [7:0] OFF_NET_CTRL  = 8'h00;
	localparam logic [7:0] OFF_NET_CFG   = 8'h04;
	localparam logic [7:0] OFF_RX_QPTR   = 8'h08;
	localparam logic [7:0] OFF_RX_STAT   = 8'h0c;
	localparam logic [7:0] OFF_CNT_FRAME = 8'h10;
	localparam logic [7:0] OFF_CNT_RES   = 8'h14;
	localparam int         NUM_CNT       = 2;
	localparam logic [7:0] OFF_CNT_BASE  = OFF_CNT_FRAME;

	// control and configuration fields
	localparam int NCR_RX_EN    = 2;
	localparam int NCR_STAT_WEN = 7;
	localparam int CFG_OFF_LO   = 14;
	localparam int RSR_RES_ERR  = 1;
	localparam int RSR_LATE     = 2;

	// descriptor layout
	localparam logic [31:0] DESC_BYTES    = 32'h0000_0008;
	localparam logic [31:0] DESC_STAT_OFF = 32'h0000_0004;
	localparam int          D0_WRAP       = 1;
	localparam int          D0_OWN        = 0;
	localparam int          BUF_BYTES     = 128;

	// status word fields
	localparam int ST_RSVD  = 27;
	localparam int ST_VLAN  = 21;
	localparam int ST_EOF   = 15;
	localparam int ST_SOF   = 14;
	localparam int ST_OFF_LO = 12;
	localparam int ST_LEN_W  = 12;

	// bus grant budget: 12 bytes take 960 ns at line rate, less 6 internal cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int FIFO_TIME_NS  = 960;
	localparam int INT_CYCLES    = 6;
	localparam int GRANT_CYC     = FIFO_TIME_NS / CLK_PERIOD_NS - INT_CYCLES;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef enum logic [6:0] {
		S_IDLE  = 7'b0000001,
		S_FETCH = 7'b0000010,
		S_FILL  = 7'b0000100,
		S_WRD   = 7'b0001000,
		S_STAT  = 7'b0010000,
		S_OWN   = 7'b0100000,
		S_DROP  = 7'b1000000
	} rxb_state_t;
endpackage : rxb_pkg

/* File: rtl/rxb_stat_ctr.sv */
`timescale 1ns/1ps
module rxb_stat_ctr import rxb_pkg::*; #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	// counting
	input  wire logic             inc,
	input  wire logic             count_en,
	// software access
	input  wire logic             rd,
	input  wire logic             wr,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] value
);
	logic [WIDTH-1:0] cnt_q;
	logic             bump;

	assign value = cnt_q;
	assign bump  = inc && count_en;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (wr && wr_en) begin
				cnt_q <= wdata;
			end else if (rd) begin
				// an event in the read cycle survives as the new first count
				cnt_q <= bump ? WIDTH'(1) : '0;
			end else if (bump && !(&cnt_q)) begin
				cnt_q <= cnt_q + WIDTH'(1);
			end
		end
	end
endmodule : rxb_stat_ctr

/* File: rtl/rxb_status_word.sv */
`timescale 1ns/1ps
module rxb_status_word import rxb_pkg::*; (
	// frame information
	input  wire logic [15:0]         match_hi,
	input  wire logic                eof,
	input  wire logic                sof,
	input  wire logic [1:0]          offset,
	input  wire logic [ST_LEN_W-1:0] length,
	// descriptor word 1
	output logic      [31:0]         word
);
	always_comb begin
		word = '0;
		word[ST_SOF] = sof;
		word[ST_OFF_LO +: 2] = offset;
		if (eof) begin
			word[31:16] = match_hi;
			word[ST_RSVD] = 1'b0;
			if (!match_hi[ST_VLAN-16]) begin
				word[19:16] = 4'h0;
			end
			word[ST_EOF] = 1'b1;
			word[ST_LEN_W-1:0] = length;
		end
	end
endmodule : rxb_status_word

/* File: bench/rxb_rx_manager_asserts.sv */
`timescale 1ns/1ps
module rxb_rx_manager_asserts import rxb_pkg::*; #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata_q,
	// receive stream and memory
	input wire logic        rx_valid,
	input wire logic        rx_ready_q,
	input wire logic        mem_req_q,
	input wire logic        mem_we_q,
	input wire logic [31:0] mem_addr_q,
	input wire logic [3:0]  mem_be_q,
	input wire logic        mem_ack
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic ever_en_q;
	logic wen_q;

	// sticky record of any receive enable write and mirror of the write enable bit, seen only through writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ever_en_q <= 1'b0;
		else if (reg_wr && reg_addr == OFF_NET_CTRL && reg_wdata[NCR_RX_EN])
			ever_en_q <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wen_q <= 1'b0;
		else if (reg_wr && reg_addr == OFF_NET_CTRL)
			wen_q <= reg_wdata[NCR_STAT_WEN];
	end

	a_rd_idle_zero: assert property (!reg_rd |=> reg_rdata_q == RST_ZERO)
		else $error("read data seen without a read");
	a_cnt_read_clears: assert property ((!mem_req_q && !rx_valid) ##1
		(reg_rd && reg_addr == OFF_CNT_RES && !mem_req_q && !rx_valid) [*2]
		|=> reg_rdata_q == RST_ZERO)
		else $error("counter not cleared by read");
	a_cnt_write_gate: assert property ((reg_wr && reg_addr == OFF_CNT_FRAME) ##1
		(reg_rd && reg_addr == OFF_CNT_FRAME && !mem_req_q && !rx_valid) |=>
		((reg_rdata_q[CNT_W-1:0] == $past(reg_wdata[CNT_W-1:0], 2)) == $past(wen_q, 2)))
		else $error("counter write gating wrong");
	a_rx_off_quiet: assert property (!ever_en_q |-> !rx_ready_q && !mem_req_q)
		else $error("receive active while never enabled");
	a_fetch_aligned: assert property (mem_req_q && !mem_we_q |-> mem_addr_q[1:0] == 2'b00)
		else $error("descriptor read not word aligned");
	a_req_held: assert property (mem_req_q && !mem_ack |=>
		mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
		else $error("memory request dropped before ack");
	a_byte_one_take: assert property (rx_valid && rx_ready_q |=> !rx_ready_q)
		else $error("ready held after a take");
	a_write_lanes: assert property (mem_req_q && mem_we_q |-> mem_be_q != 4'h0)
		else $error("memory write with no byte lane");
endmodule : rxb_rx_manager_asserts

/* File: bench/rxb_mem_model.sv */
`timescale 1ns/1ps
module rxb_mem_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// bus from the receive manager
	input  wire logic        mem_req_q,
	input  wire logic        mem_we_q,
	input  wire logic [31:0] mem_addr_q,
	input  wire logic [31:0] mem_wdata_q,
	input  wire logic [3:0]  mem_be_q,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] mem [256];
	int          lat = 0;
	int          cnt;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			cnt       <= 0;
		end else if (mem_req_q && !mem_ack && cnt >= lat) begin
			// grant inside the budget unless a test slows the bus on purpose
			mem_ack   <= 1'b1;
			mem_rdata <= mem[mem_addr_q[9:2]];
			cnt       <= 0;
			for (int b = 0; b < 4; b++)
				if (mem_we_q && mem_be_q[b])
					mem[mem_addr_q[9:2]][b*8 +: 8] <= mem_wdata_q[b*8 +: 8];
		end else begin
			// read data is only good with the ack, so scramble it otherwise
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt       <= (mem_req_q && !mem_ack) ? cnt + 1 : 0;
		end
	end
endmodule : rxb_mem_model

/* File: bench/rxb_rx_manager_tb.sv */
`timescale 1ns/1ps
module rxb_rx_manager_tb import rxb_pkg::*; ;
	typedef struct packed {
		logic wr; logic rd; logic [7:0] a; logic [31:0] d; logic [31:0] e;
	} rxb_row_t;
	localparam rxb_row_t ROWS [11] = '{
		'{1'b1, 1'b0, OFF_NET_CTRL, 32'h84, 32'h0},
		'{1'b1, 1'b0, OFF_CNT_RES, 32'h1234, 32'h0},
		'{1'b0, 1'b1, OFF_CNT_RES, 32'h0, 32'h1234},
		'{1'b0, 1'b1, OFF_CNT_RES, 32'h0, 32'h0},
		'{1'b1, 1'b0, OFF_NET_CTRL, 32'h04, 32'h0},
		'{1'b1, 1'b0, OFF_CNT_FRAME, 32'h5, 32'h0},
		'{1'b0, 1'b1, OFF_CNT_FRAME, 32'h0, 32'h0},
		'{1'b0, 1'b1, 8'h1c, 32'h0, 32'h0},
		'{1'b1, 1'b0, OFF_NET_CFG, 32'h8000, 32'h0},
		'{1'b1, 1'b0, OFF_RX_QPTR, 32'h40, 32'h0},
		'{1'b0, 1'b1, OFF_RX_QPTR, 32'h0, 32'h40}};

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        rx_valid = 1'b1;
	logic        rx_last = 1'b0;
	logic [7:0]  rx_data = 8'h00;
	logic [15:0] rx_match = 16'hfe3b;
	logic [31:0] reg_rdata_q, mem_addr_q, mem_wdata_q, mem_rdata, rd_v;
	logic [3:0]  mem_be_q;
	logic        rx_ready_q, mem_req_q, mem_we_q, mem_ack;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t;

	always #5 clk = ~clk;

	rxb_rx_manager #(.CNT_W(16)) rxb_rx_manager_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_match(rx_match), .rx_ready_q(rx_ready_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
		.mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_be_q(mem_be_q),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	rxb_mem_model rxb_mem_model_inst (.clk(clk), .rst_n(rst_n), .mem_req_q(mem_req_q),
		.mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
		.mem_be_q(mem_be_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		rd_v = reg_rdata_q;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// one byte per take; data is the byte index so placement can be checked
	task automatic send(input int n);
		for (int k = 0; k < n; k++) begin
			rx_valid <= 1'b1;
			rx_data  <= k[7:0];
			rx_last  <= (k == n - 1);
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (rx_ready_q !== 1'b1 && t < 500);
			chk("byte taken", 32'h1, {31'h0, t < 500});
		end
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
	endtask : send

	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		rxb_mem_model_inst.mem[16] = 32'h0000_0100;
		rxb_mem_model_inst.mem[18] = 32'h0000_0202;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk("quiet while disabled", 32'h0, {30'h0, rx_ready_q, mem_req_q});
		rx_valid <= 1'b0;
		$display("reset test done");

		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			reg_wr    <= (i < 11) ? ROWS[i % 11].wr : 1'b0;
			reg_rd    <= (i < 11) ? ROWS[i % 11].rd : 1'b0;
			reg_addr  <= ROWS[i % 11].a;
			reg_wdata <= ROWS[i % 11].d;
			#1;
			if (i > 0 && ROWS[i - 1].rd)
				chk("table read", ROWS[i - 1].e, reg_rdata_q);
		end
		$display("register table done");

		// offset 2 leaves 126 bytes in the first buffer, so 130 bytes spill 4
		send(130);
		t = 0;
		while (rxb_mem_model_inst.mem[18][0] !== 1'b1 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		repeat (3) @(posedge clk);
		chk("spill status", 32'h0000_6000, rxb_mem_model_inst.mem[17]);
		chk("first word0", 32'h0000_0101, rxb_mem_model_inst.mem[16]);
		chk("last word0", 32'h0000_0203, rxb_mem_model_inst.mem[18]);
		chk("last status", 32'hf63b_8082, rxb_mem_model_inst.mem[19]);
		chk("first bytes", 32'h0100, {16'h0, rxb_mem_model_inst.mem[64][31:16]});
		chk("buffer end", 32'h7d7c_7b7a, rxb_mem_model_inst.mem[95]);
		chk("spilled bytes", 32'h8180_7f7e, rxb_mem_model_inst.mem[128]);
		rd(OFF_CNT_FRAME);
		chk("frame count", 32'h1, rd_v);
		rd(OFF_RX_QPTR);
		chk("wrapped pointer", 32'h40, rd_v);
		$display("spill frame test done");

		// descriptor still owned and a bus slower than the grant budget
		rxb_mem_model_inst.lat = 95;
		send(3);
		t = 0;
		rd(OFF_RX_STAT);
		while (rd_v[0] !== 1'b0 && t < 300) begin
			rd(OFF_RX_STAT);
			t++;
		end
		chk("late and resource flags", 32'h6, rd_v & 32'h6);
		chk("owned buffer kept", 32'h0100, {16'h0, rxb_mem_model_inst.mem[64][31:16]});
		chk("owned word0 kept", 32'h0000_0101, rxb_mem_model_inst.mem[16]);
		rd(OFF_CNT_RES);
		chk("resource count", 32'h1, rd_v);
		$display("owned descriptor test done");

		// a write while the clock enable is low must not land; a live one clears
		@(posedge clk);
		clk_en <= 1'b0;
		wr(OFF_RX_STAT, 32'h6);
		clk_en <= 1'b1;
		rd(OFF_RX_STAT);
		chk("flags kept while frozen", 32'h6, rd_v & 32'h6);
		wr(OFF_RX_STAT, 32'h6);
		rd(OFF_RX_STAT);
		chk("flags cleared", 32'h0, rd_v & 32'h6);
		$display("freeze and clear test done");
		test_done();
	end
endmodule : rxb_rx_manager_tb

bind rxb_rx_manager rxb_rx_manager_asserts #(.CNT_W(CNT_W)) rxb_rx_manager_asserts_inst (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .rx_valid(rx_valid), .rx_ready_q(rx_ready_q),
	.mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_be_q(mem_be_q),
	.mem_ack(mem_ack));
